/* test/xss_mem_model.sv */
// behavioural save area memory answering the engine's master port
`timescale 1ns/1ps
module xss_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        memCyc,
  input  wire logic        memWe,
  input  wire logic [31:0] memAdr,
  input  wire logic [63:0] memDatW,
  output logic [63:0]      memDatR,
  output logic             memAck
);
  logic [63:0] store   [logic [31:0]];
  bit          acc     [logic [31:0]];
  int          lat     = 0;
  int          waitCnt = 0;

  initial begin
    memAck  = 1'b0;
    memDatR = 64'h0;
  end

  // one answer per request after lat cycles; read data toggles outside the ack so stale data is caught
  always @(posedge clk_sys) begin
    if (memCyc && !memAck && waitCnt >= lat) begin
      memAck      <= 1'b1;
      waitCnt     <= 0;
      acc[memAdr] = 1'b1;
      if (memWe)
        store[memAdr] = memDatW;
      else
        memDatR <= store.exists(memAdr) ? store[memAdr] : 64'h0;
    end else begin
      memAck  <= 1'b0;
      memDatR <= ~memDatR;
      waitCnt <= (memCyc && !memAck) ? waitCnt + 1 : 0;
    end
  end
endmodule // xss_mem_model

/* test/xss_top_bench.sv */
// self-checking bench for the extended state save/restore engine
`timescale 1ns/1ps
module xss_top_bench;
  localparam logic [31:0] BASE = 32'h0000_1000;
  localparam logic [31:0] BAD_HI [3] = '{32'h1, 32'h0, 32'h0};
  localparam logic [31:0] BAD_LO [3] = '{32'h7, 32'h6, 32'h5};
  logic        clk_sys, srst, wbCyc, wbStb, wbWe, wbAck, memCyc, memWe, memAck, busy, gpf;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW, wbDatR, memAdr;
  logic [63:0] memDatW, memDatR;
  int          miscompares = 0;
  int          samplesChecked = 0;
  int          cycles = 0;
  int          gpfPulses = 0;

  xss_top uut (.clk_sys(clk_sys), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .memCyc(memCyc), .memWe(memWe),
    .memAdr(memAdr), .memDatW(memDatW), .memDatR(memDatR), .memAck(memAck), .busy(busy),
    .generalProtectionFault(gpf));
  xss_mem_model mem (.clk_sys(clk_sys), .memCyc(memCyc), .memWe(memWe), .memAdr(memAdr),
    .memDatW(memDatW), .memDatR(memDatR), .memAck(memAck));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("checked %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, far above the fewer than two thousand cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (gpf === 1'b1)
      gpfPulses++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // classic single cycle; held until ack is sampled, read data taken at that edge
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'b11, we, adr, dat};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatR;
    {wbCyc, wbStb, wbWe} <= 3'b000;
    if (n >= 50)
      chk(1'b0, 1'b1, "bus ack timeout");
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] r;
    wbXfer(1'b1, adr, dat, r);
  endtask

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] r;
    wbXfer(1'b0, adr, 32'h0, r);
    chk(r, exp, what);
  endtask

  // enable pair: high word only stages, low word commits
  task automatic setFec(input logic [31:0] hi, input logic [31:0] lo);
    wr(xss_pkg::REG_FEC_HI, hi);
    wr(xss_pkg::REG_FEC_LO, lo);
  endtask

  task automatic runOp(input logic [31:0] ctrl, input int latency);
    int n;
    n = 0;
    mem.store.delete();
    mem.acc.delete();
    mem.lat = latency;
    wr(xss_pkg::REG_CTRL, ctrl);
    repeat (2) @(posedge clk_sys);
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(busy, 1'b0, "operation end");
  endtask

  initial begin
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW} = '0;
    wbSel = 4'hF;
    srst  = 1'b1;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    rdChk(xss_pkg::REG_FEC_LO, 32'h1, "enable reset");
    rdChk(xss_pkg::REG_STATUS, 32'h0, "status reset");
    rdChk(8'h30, 32'h0, "unmapped read");
    $display("test reset done");
    // high bits set, x87 clear, upper halves without vector
    for (int i = 0; i < 3; i++) begin
      setFec(BAD_HI[i], BAD_LO[i]);
      rdChk(xss_pkg::REG_STATUS, 32'h2, "fault flag");
      rdChk(xss_pkg::REG_FEC_LO, 32'h1, "enable kept");
      wr(xss_pkg::REG_STATUS, 32'h2);
    end
    chk(gpfPulses, 3, "fault pulses");
    setFec(32'h0, 32'h7);
    rdChk(xss_pkg::REG_FEC_LO, 32'h7, "enable legal");
    chk(gpfPulses, 3, "no fault on legal write");
    $display("test enable done");
    wr(xss_pkg::REG_BASE, BASE);
    wr(xss_pkg::REG_MASK_HI, 32'h0);
    wr(xss_pkg::REG_MASK_LO, 32'h7);
    // restore, 64-bit, x87 and vector present, upper halves absent
    fork
      runOp(32'h6, 2);
      begin
        @(posedge clk_sys);
        mem.store[BASE + 32'h200] = 64'h3;
        mem.store[BASE] = 64'h0000_00A5_0080_1234;
        mem.store[BASE + 32'h18] = 64'h0000_1F80;
        mem.store[BASE + 32'hA0] = 64'hC0DE_0000_0000_0001;
        mem.store[BASE + 32'h198] = 64'h5;
      end
    join
    rdChk(xss_pkg::REG_FPCS, 32'h0080_1234, "loaded fp words");
    rdChk(xss_pkg::REG_FTW, 32'hA5, "loaded tags");
    rdChk(xss_pkg::REG_MEDIA_CONTROL_STATUS_WORD, 32'h1F80, "loaded media word");
    chk(mem.acc.exists(BASE + 32'h200), 1, "header read");
    chk(mem.acc.exists(BASE + 32'h8), 1, "pointer read when pending");
    chk(mem.acc.exists(BASE + 32'h240), 0, "absent halves not read");
    $display("test restore present done");
    // save vector only, after ordinary save semantics
    wr(xss_pkg::REG_MASK_LO, 32'h2);
    runOp(32'h5, 0);
    chk(mem.store[BASE + 32'h200], 64'h2, "bitmap after save");
    chk(mem.store[BASE + 32'hA0], 64'hC0DE_0000_0000_0001, "vector 0 saved");
    chk(mem.store[BASE + 32'h198], 64'h5, "vector 15 saved");
    chk(mem.store[BASE + 32'h18], 64'h0000_FFFF_0000_1F80, "media word saved");
    chk(mem.acc.exists(BASE), 0, "x87 not saved");
    $display("test save done");
    // restore outside 64-bit mode, everything absent
    setFec(32'h0, 32'h3);
    wr(xss_pkg::REG_MASK_LO, 32'h7);
    fork
      runOp(32'h2, 3);
      begin
        @(posedge clk_sys);
        mem.store[BASE + 32'h18] = 64'h1F00;
      end
    join
    rdChk(xss_pkg::REG_FPCS, 32'h0000_037F, "fp init words");
    rdChk(xss_pkg::REG_FTW, 32'h0, "tags empty");
    rdChk(xss_pkg::REG_MEDIA_CONTROL_STATUS_WORD, 32'h1F00, "media word read");
    chk(mem.acc.exists(BASE + 32'h8), 0, "pointer skipped");
    chk(mem.acc.exists(BASE + 32'h240), 0, "halves not selected");
    // narrow save must not reach the high vector slots
    wr(xss_pkg::REG_MASK_LO, 32'h2);
    runOp(32'h1, 1);
    chk(mem.acc.exists(BASE + 32'h120), 0, "high vectors skipped");
    chk(mem.store[BASE + 32'hA0], 64'h0, "vector 0 initialised");
    runOp(32'h5, 1);
    chk(mem.store[BASE + 32'h198], 64'h5, "vector 15 kept");
    chk(mem.store[BASE + 32'h200], 64'h2, "bitmap order");
    // upper halves only: the last image word is written, then the header
    setFec(32'h0, 32'h7);
    wr(xss_pkg::REG_MASK_LO, 32'h4);
    runOp(32'h5, 0);
    chk(mem.acc.exists(BASE + 32'h338), 1, "upper half 15 saved");
    chk(mem.store[BASE + 32'h200], 64'h4, "halves bitmap");
    $display("test restore absent done");
    conclude();
  end
endmodule // xss_top_bench

bind xss_top xss_top_props props (.clk_sys(clk_sys), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
  .wbAdr(wbAdr), .wbDatR(wbDatR), .wbAck(wbAck), .memCyc(memCyc), .memWe(memWe), .memAdr(memAdr),
  .memAck(memAck), .busy(busy), .generalProtectionFault(generalProtectionFault));

/* test/xss_top_props.sv */
// port-level checks for the extended state save/restore engine
`timescale 1ns/1ps
module xss_top_props (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbWe,
  input wire logic [7:0]  wbAdr,
  input wire logic [31:0] wbDatR,
  input wire logic        wbAck,
  input wire logic        memCyc,
  input wire logic        memWe,
  input wire logic [31:0] memAdr,
  input wire logic        memAck,
  input wire logic        busy,
  input wire logic        generalProtectionFault
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // bus request taken, and memory word completed
  sequence reqTaken;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence memDone;
    memCyc && memAck;
  endsequence

  a_ack_next: assert property (reqTaken |=> wbAck) else $error("bus ack missing");
  a_ack_pulse: assert property (wbAck |=> !wbAck) else $error("bus ack held too long");
  a_unmapped_zero: assert property (wbAck && !wbWe && wbAdr == 8'h30 |-> wbDatR == 32'h0)
    else $error("unmapped read not zero");
  a_mem_hold: assert property (memCyc && !memAck |=> memCyc && $stable(memAdr) && $stable(memWe))
    else $error("memory request changed before answer");
  a_mem_release: assert property (memDone |=> !memCyc) else $error("memory request not released");
  a_mem_in_op: assert property (memCyc |-> busy) else $error("memory access while idle");
  a_gpf_cause: assert property ($rose(generalProtectionFault) |->
    $past(wbCyc && wbStb && wbWe && wbAdr == xss_pkg::REG_FEC_LO))
    else $error("fault without enable write");
  a_gpf_pulse: assert property (generalProtectionFault |=> !generalProtectionFault)
    else $error("fault pulse too long");
  // a whole pass over the image stays well under this bound at the bench latencies
  a_op_bounded: assert property ($rose(busy) |-> ##[1:1000] !busy) else $error("operation never ends");
endmodule // xss_top_props

/* verilog/xss_fec_check.sv */
// feature enable write validation and effective component selection
`timescale 1ns/1ps
module xss_fec_check (
  input  wire logic [63:0] proposed,
  input  wire logic [63:0] fec,
  input  wire logic [63:0] mask,
  output logic             legal,
  output logic [2:0]       effSel
);

  // reject high bits, missing x87 bit, upper halves without vector state
  always_comb begin
    legal = (proposed[63:3] == 61'h0) && proposed[xss_pkg::FEC_X87] &&
            (proposed[xss_pkg::FEC_YMM:xss_pkg::FEC_VEC] != 2'h2);
  end

  // only components set in both operand and enable take part
  always_comb begin
    effSel = mask[2:0] & fec[2:0];
  end

endmodule // xss_fec_check

/* verilog/xss_item_map.sv */
// maps a step number onto one 64-bit word of the save area image
`timescale 1ns/1ps
module xss_item_map #(
  parameter logic [11:0] YMM_BASE = xss_pkg::YMM_AREA_OFFSET
) (
  input  wire logic [6:0]        itemNum,
  output xss_pkg::xss_item_s     item
);

  logic [6:0] j;

  // legacy image first, then upper halves area; two words per 128-bit register
  always_comb begin
    item = '0;
    j    = 7'h00;
    if (itemNum == 7'h00) begin
      item.kind = xss_pkg::KIND_FPHDR;
    end else if (itemNum == 7'h01) begin
      item.kind   = xss_pkg::KIND_FIP;
      item.offset = 12'h008;
    end else if (itemNum == 7'h02) begin
      item.kind   = xss_pkg::KIND_FDP;
      item.offset = 12'h010;
    end else if (itemNum == 7'h03) begin
      item.kind   = xss_pkg::KIND_MEDIA_CONTROL_STATUS_WORD;
      item.offset = 12'h018;
    end else if (itemNum < 7'h14) begin
      j           = itemNum - 7'h04;
      item.kind   = xss_pkg::KIND_ST;
      item.offset = xss_pkg::ST_OFFSET + {2'h0, j, 3'h0};
    end else if (itemNum < 7'h34) begin
      j           = itemNum - 7'h14;
      item.kind   = xss_pkg::KIND_XMM;
      item.offset = xss_pkg::XMM_OFFSET + {2'h0, j, 3'h0};
    end else begin
      j           = itemNum - 7'h34;
      item.kind   = xss_pkg::KIND_YMM;
      item.offset = YMM_BASE + {2'h0, j, 3'h0};
    end
    item.regIdx = j[4:1];
    item.upper  = j[0];
  end

endmodule // xss_item_map

/* verilog/xss_pkg.sv */
// shared constants, types and state layout for the extended state save/restore engine
package xss_pkg;

  // register bus byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_MASK_LO = 8'h08;
  localparam logic [7:0] REG_MASK_HI = 8'h0C;
  localparam logic [7:0] REG_FEC_LO  = 8'h10;
  localparam logic [7:0] REG_FEC_HI  = 8'h14;
  localparam logic [7:0] REG_BASE    = 8'h18;
  localparam logic [7:0] REG_FPCS    = 8'h1C;
  localparam logic [7:0] REG_MEDIA_CONTROL_STATUS_WORD   = 8'h20;
  localparam logic [7:0] REG_FTW     = 8'h24;
  localparam logic [7:0] REG_BMP_LO  = 8'h28;

  // control and status bit positions
  localparam int CTRL_SAVE    = 0;
  localparam int CTRL_RESTORE = 1;
  localparam int CTRL_MODE64  = 2;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_GPF     = 1;

  // feature enable bits, shared by the saved-component bitmap
  localparam int FEC_X87 = 0;
  localparam int FEC_VEC = 1;
  localparam int FEC_YMM = 2;
  localparam logic [63:0] FEC_RESET = 64'h0000_0000_0000_0001;

  // save area layout, byte offsets
  localparam logic [11:0] HDR_OFFSET      = 12'h200;
  localparam logic [11:0] ST_OFFSET       = 12'h020;
  localparam logic [11:0] XMM_OFFSET      = 12'h0A0;
  localparam logic [11:0] YMM_AREA_OFFSET = 12'h240;
  localparam logic [6:0]  ITEM_LAST       = 7'h53;

  // initial values for components marked absent
  localparam logic [15:0] FCW_INIT   = 16'h037F;
  localparam logic [15:0] FSW_INIT   = 16'h0000;
  localparam logic [7:0]  FTW_INIT   = 8'h00;
  localparam int          FSW_ES_BIT = 7;

  typedef enum logic [2:0] {
    KIND_FPHDR, KIND_FIP, KIND_FDP, KIND_MEDIA_CONTROL_STATUS_WORD, KIND_ST, KIND_XMM, KIND_YMM
  } xss_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HDR   = 3'b001,
    ST_INIT  = 3'b011,
    ST_ITEM  = 3'b010,
    ST_HDRWR = 3'b110
  } xss_state_e;

  typedef struct packed {
    xss_kind_e   kind;
    logic [3:0]  regIdx;
    logic        upper;
    logic [11:0] offset;
  } xss_item_s;

  typedef struct packed {
    logic        cyc;
    logic        we;
    logic [31:0] adr;
    logic [63:0] datW;
  } xss_mem_req_s;

  typedef struct packed {
    xss_state_e         state;
    logic [6:0]         itemNum;
    logic               isRestore;
    logic               busy;
    logic               wbAck;
    logic [31:0]        wbDatR;
    xss_mem_req_s       mem;
    logic               mode64;
    logic               gpFlag;
    logic               gpPulse;
    logic [63:0]        mask;
    logic [63:0]        fec;
    logic [31:0]        fecHiStage;
    logic [31:0]        base;
    logic [63:0]        bitmap;
    logic [2:0]         sel;
    logic [15:0]        fp_control_word;
    logic [15:0]        fp_status_word;
    logic [7:0]         fp_tag_word;
    logic [15:0]        fop;
    logic [63:0]        fip;
    logic [63:0]        fdp;
    logic [31:0]        media_control_status_word;
    logic [7:0][79:0]   st;
    logic [15:0][127:0] vector_registers;
    logic [15:0][127:0] ymm;
  } xss_regs_s;

endpackage

/* verilog/xss_top.sv */
// extended state save/restore engine with wishbone registers and save area master
// Overview of operation
// - header sits at byte 512 of area
// - bitmap is the header's first 64-bit word
// - bitmap bits ordered like feature enable bits
// - saving a component sets its bitmap bit
// - save touches only mask AND enable components
// - restore updates only mask AND enable components
// - bitmap bit set: load component from memory
// - bitmap bit clear: load fixed initial values
// - x87 init: 037F, 0000, tags empty, zeros
// - vector init: sixteen in 64-bit, else eight
// - upper halves init: sixteen or eight likewise
// - media control word loaded whenever vector or upper halves selected, never initialised
// - skip error pointers without pending fp exception
// - registers 8-15 untouched outside 64-bit mode
// - bad feature enable write raises protection fault
// - bit0 x87, bit1 vector, bit2 upper halves
`timescale 1ns/1ps
module xss_top #(
  parameter logic [11:0] YMM_BASE   = xss_pkg::YMM_AREA_OFFSET,
  parameter logic [31:0] MEDIA_CONTROL_STATUS_WORD_MASK = 32'h0000_FFFF
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic [31:0]      wbDatR,
  output logic             wbAck,
  output logic             memCyc,
  output logic             memWe,
  output logic [31:0]      memAdr,
  output logic [63:0]      memDatW,
  input  wire logic [63:0] memDatR,
  input  wire logic        memAck,
  output logic             busy,
  output logic             generalProtectionFault
);

  xss_pkg::xss_regs_s r;
  xss_pkg::xss_regs_s next_r;
  xss_pkg::xss_item_s item;
  logic               fecLegal;
  logic [2:0]         effSel;
  logic               compSel;
  logic               loadBit;
  logic               active;
  logic               wbReq;
  logic [63:0]        proposedFec;
  logic [63:0]        saveWord;

  // byte-lane merge for writable registers
  function automatic logic [31:0] applySel(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = nv[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // registers 8-15 exist only in 64-bit mode
  function automatic logic regPresent(input logic [3:0] idx, input logic m64);
    return m64 || !idx[3];
  endfunction

  assign wbReq       = wbCyc && wbStb && !r.wbAck;
  assign proposedFec = {r.fecHiStage, applySel(r.fec[31:0], wbDatW, wbSel)};

  xss_fec_check u_fec (
    .proposed (proposedFec),
    .fec      (r.fec),
    .mask     (r.mask),
    .legal    (fecLegal),
    .effSel   (effSel)
  );

  xss_item_map #(.YMM_BASE(YMM_BASE)) u_map (
    .itemNum (r.itemNum),
    .item    (item)
  );

  // does the current step touch memory
  always_comb begin
    compSel = 1'b0;
    loadBit = 1'b1;
    unique case (item.kind)
      xss_pkg::KIND_FPHDR, xss_pkg::KIND_ST: begin
        compSel = r.sel[xss_pkg::FEC_X87];
        loadBit = r.bitmap[xss_pkg::FEC_X87];
      end
      xss_pkg::KIND_FIP, xss_pkg::KIND_FDP: begin
        // fsw is already the loaded one on restore, so this tests the incoming state
        compSel = r.sel[xss_pkg::FEC_X87] && r.fp_status_word[xss_pkg::FSW_ES_BIT];
        loadBit = r.bitmap[xss_pkg::FEC_X87];
      end
      xss_pkg::KIND_MEDIA_CONTROL_STATUS_WORD: begin
        compSel = r.sel[xss_pkg::FEC_VEC] || r.sel[xss_pkg::FEC_YMM];
        loadBit = 1'b1;
      end
      xss_pkg::KIND_XMM: begin
        compSel = r.sel[xss_pkg::FEC_VEC] && regPresent(item.regIdx, r.mode64);
        loadBit = r.bitmap[xss_pkg::FEC_VEC];
      end
      xss_pkg::KIND_YMM: begin
        compSel = r.sel[xss_pkg::FEC_YMM] && regPresent(item.regIdx, r.mode64);
        loadBit = r.bitmap[xss_pkg::FEC_YMM];
      end
    endcase
    active = compSel && (!r.isRestore || loadBit);
  end

  // image word for the current save step
  always_comb begin
    saveWord = 64'h0;
    unique case (item.kind)
      xss_pkg::KIND_FPHDR: saveWord = {r.fop, 8'h00, r.fp_tag_word, r.fp_status_word, r.fp_control_word};
      xss_pkg::KIND_FIP:   saveWord = r.fip;
      xss_pkg::KIND_FDP:   saveWord = r.fdp;
      xss_pkg::KIND_MEDIA_CONTROL_STATUS_WORD: saveWord = {MEDIA_CONTROL_STATUS_WORD_MASK, r.media_control_status_word};
      xss_pkg::KIND_ST:    saveWord = item.upper ? {48'h0, r.st[item.regIdx[2:0]][79:64]}
                                                 : r.st[item.regIdx[2:0]][63:0];
      xss_pkg::KIND_XMM:   saveWord = r.vector_registers[item.regIdx][item.upper*64 +: 64];
      xss_pkg::KIND_YMM:   saveWord = r.ymm[item.regIdx][item.upper*64 +: 64];
    endcase
  end

  // whole next state: bus slave, sequencer, architectural registers
  always_comb begin
    next_r         = r;
    next_r.gpPulse = 1'b0;
    next_r.wbAck   = wbReq;

    // register reads, unmapped reads return zero
    if (wbReq) begin
      next_r.wbDatR = 32'h0;
      unique case (wbAdr)
        xss_pkg::REG_CTRL:    next_r.wbDatR = {29'h0, r.mode64, 2'h0};
        xss_pkg::REG_STATUS:  next_r.wbDatR = {30'h0, r.gpFlag, r.busy};
        xss_pkg::REG_MASK_LO: next_r.wbDatR = r.mask[31:0];
        xss_pkg::REG_MASK_HI: next_r.wbDatR = r.mask[63:32];
        xss_pkg::REG_FEC_LO:  next_r.wbDatR = r.fec[31:0];
        xss_pkg::REG_FEC_HI:  next_r.wbDatR = r.fec[63:32];
        xss_pkg::REG_BASE:    next_r.wbDatR = r.base;
        xss_pkg::REG_FPCS:    next_r.wbDatR = {r.fp_status_word, r.fp_control_word};
        xss_pkg::REG_MEDIA_CONTROL_STATUS_WORD:   next_r.wbDatR = r.media_control_status_word;
        xss_pkg::REG_FTW:     next_r.wbDatR = {24'h0, r.fp_tag_word};
        xss_pkg::REG_BMP_LO:  next_r.wbDatR = r.bitmap[31:0];
        default:              next_r.wbDatR = 32'h0;
      endcase
    end

    // register writes
    if (wbReq && wbWe) begin
      unique case (wbAdr)
        xss_pkg::REG_CTRL: begin
          if (wbSel[0]) begin
            next_r.mode64 = wbDatW[xss_pkg::CTRL_MODE64];
          end
          if (wbSel[0] && r.state == xss_pkg::ST_IDLE &&
              (wbDatW[xss_pkg::CTRL_SAVE] || wbDatW[xss_pkg::CTRL_RESTORE])) begin
            next_r.isRestore = wbDatW[xss_pkg::CTRL_RESTORE] && !wbDatW[xss_pkg::CTRL_SAVE];
            next_r.sel       = effSel;
            next_r.busy      = 1'b1;
            next_r.itemNum   = 7'h00;
            next_r.state     = xss_pkg::ST_HDR;
            next_r.mem.cyc   = 1'b1;
            next_r.mem.we    = 1'b0;
            next_r.mem.adr   = r.base + {20'h0, xss_pkg::HDR_OFFSET};
          end
        end
        xss_pkg::REG_STATUS: begin
          if (wbSel[0] && wbDatW[xss_pkg::STAT_GPF]) begin
            next_r.gpFlag = 1'b0;
          end
        end
        xss_pkg::REG_MASK_LO: next_r.mask[31:0]  = applySel(r.mask[31:0], wbDatW, wbSel);
        xss_pkg::REG_MASK_HI: next_r.mask[63:32] = applySel(r.mask[63:32], wbDatW, wbSel);
        xss_pkg::REG_FEC_HI:  next_r.fecHiStage  = applySel(r.fecHiStage, wbDatW, wbSel);
        xss_pkg::REG_FEC_LO: begin
          // low word commits all 64 bits, so a bad value never lands half-written
          if (fecLegal) begin
            next_r.fec = proposedFec;
          end else begin
            next_r.gpPulse = 1'b1;
          end
        end
        xss_pkg::REG_BASE: next_r.base = applySel(r.base, wbDatW, wbSel);
        default: begin
        end
      endcase
    end

    // sequencer
    unique case (r.state)
      xss_pkg::ST_IDLE: begin
      end
      xss_pkg::ST_HDR: begin
        if (memAck) begin
          next_r.mem.cyc = 1'b0;
          next_r.bitmap  = memDatR;
          next_r.state   = r.isRestore ? xss_pkg::ST_INIT : xss_pkg::ST_ITEM;
        end
      end
      xss_pkg::ST_INIT: begin
        // absent components take initial values without any memory access
        if (r.sel[xss_pkg::FEC_X87] && !r.bitmap[xss_pkg::FEC_X87]) begin
          next_r.fp_control_word = xss_pkg::FCW_INIT;
          next_r.fp_status_word = xss_pkg::FSW_INIT;
          next_r.fp_tag_word = xss_pkg::FTW_INIT;
          next_r.fop = 16'h0000;
          next_r.fip = 64'h0;
          next_r.fdp = 64'h0;
          next_r.st  = '0;
        end
        for (int i = 0; i < 16; i++) begin
          if (r.sel[xss_pkg::FEC_VEC] && !r.bitmap[xss_pkg::FEC_VEC] && regPresent(4'(i), r.mode64)) begin
            next_r.vector_registers[i] = 128'h0;
          end
          if (r.sel[xss_pkg::FEC_YMM] && !r.bitmap[xss_pkg::FEC_YMM] && regPresent(4'(i), r.mode64)) begin
            next_r.ymm[i] = 128'h0;
          end
        end
        next_r.state = xss_pkg::ST_ITEM;
      end
      xss_pkg::ST_ITEM: begin
        if (!r.mem.cyc) begin
          if (active) begin
            next_r.mem.cyc  = 1'b1;
            next_r.mem.we   = !r.isRestore;
            next_r.mem.adr  = r.base + {20'h0, item.offset};
            next_r.mem.datW = saveWord;
          end else if (r.itemNum == xss_pkg::ITEM_LAST) begin
            next_r.state = r.isRestore ? xss_pkg::ST_IDLE : xss_pkg::ST_HDRWR;
          end else begin
            next_r.itemNum = r.itemNum + 7'h01;
          end
        end else if (memAck) begin
          next_r.mem.cyc = 1'b0;
          if (r.isRestore) begin
            unique case (item.kind)
              xss_pkg::KIND_FPHDR: begin
                next_r.fp_control_word = memDatR[15:0];
                next_r.fp_status_word = memDatR[31:16];
                next_r.fp_tag_word = memDatR[39:32];
                next_r.fop = memDatR[63:48];
              end
              xss_pkg::KIND_FIP:   next_r.fip   = memDatR;
              xss_pkg::KIND_FDP:   next_r.fdp   = memDatR;
              xss_pkg::KIND_MEDIA_CONTROL_STATUS_WORD: next_r.media_control_status_word = memDatR[31:0];
              xss_pkg::KIND_ST: begin
                if (item.upper) begin
                  next_r.st[item.regIdx[2:0]][79:64] = memDatR[15:0];
                end else begin
                  next_r.st[item.regIdx[2:0]][63:0] = memDatR;
                end
              end
              xss_pkg::KIND_XMM: next_r.vector_registers[item.regIdx][item.upper*64 +: 64] = memDatR;
              xss_pkg::KIND_YMM: next_r.ymm[item.regIdx][item.upper*64 +: 64] = memDatR;
            endcase
          end
          if (r.itemNum == xss_pkg::ITEM_LAST) begin
            next_r.state = r.isRestore ? xss_pkg::ST_IDLE : xss_pkg::ST_HDRWR;
          end else begin
            next_r.itemNum = r.itemNum + 7'h01;
          end
        end
        if (next_r.state == xss_pkg::ST_HDRWR) begin
          // saved components get their bits set, unselected bits stay as read
          next_r.bitmap = r.bitmap | {61'h0, r.sel};
        end
        if (next_r.state == xss_pkg::ST_IDLE) begin
          next_r.busy = 1'b0;
        end
      end
      xss_pkg::ST_HDRWR: begin
        // header write waits for an idle cycle, so a last item just acked never runs into it
        if (!r.mem.cyc) begin
          next_r.mem.cyc  = 1'b1;
          next_r.mem.we   = 1'b1;
          next_r.mem.adr  = r.base + {20'h0, xss_pkg::HDR_OFFSET};
          next_r.mem.datW = r.bitmap;
        end else if (memAck) begin
          next_r.mem.cyc = 1'b0;
          next_r.busy    = 1'b0;
          next_r.state   = xss_pkg::ST_IDLE;
        end
      end
      default: begin
        next_r.state   = xss_pkg::ST_IDLE;
        next_r.busy    = 1'b0;
        next_r.mem.cyc = 1'b0;
      end
    endcase

    // fault flag: a new fault beats a same-cycle clear
    if (next_r.gpPulse) begin
      next_r.gpFlag = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r     <= '0;
      r.fec <= xss_pkg::FEC_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign wbDatR                 = r.wbDatR;
  assign wbAck                  = r.wbAck;
  assign memCyc                 = r.mem.cyc;
  assign memWe                  = r.mem.we;
  assign memAdr                 = r.mem.adr;
  assign memDatW                = r.mem.datW;
  assign busy                   = r.busy;
  assign generalProtectionFault = r.gpPulse;

endmodule // xss_top
